// >>> verilog/lps_manager.sv
// lps_manager: holds the current and five standard parameter sets of the
// network-side transceiver and runs set changes over the overhead channel.
// assumes single-cycle entry strobes from the link state machine and a
// remote end that answers each message with one ack or nak pulse.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: hold current set and five standard sets
// RULE2: default set is constant, used for cold-start
// RULE3: default: 573.75k, 1451.25k, 4 bit, single latency
// RULE4: second upstream carrier off with splitter present
// RULE5: warm-start set starts equal to default; reset loads us2_enable as 0, not ~splitter_present
// RULE6: warm-start set changed over overhead channel
// RULE7: warm-resume set copies current on steady entry
// RULE8: error-resume set tracks current in steady/idle
// RULE9: idle set copies current, 4 bit, lower psd
// RULE10: idle psd cut capped by steady constellation size
// RULE11: custom idle set agreed before idle request
// RULE12: only network side modifies; default never changes
// RULE13: customer side may refuse non-standard change
// RULE14: only warm/idle sets alone, only in steady
// RULE15: send new set, store both ends on accept
// RULE16: activation entry overwrites current from its set
// RULE17: else current changes only after trigger handshake
// RULE18: change/idle in steady, back-to-service in idle
// RULE19: generic: set, change message, handshake applies
// RULE20: idle/resume handshake loads idle/warm-resume set
// RULE21: failed change recovers via error-resume set
// RULE22: warm-start set route with cold-start fallback
// RULE23: current set equals transmitter settings in use
// RULE24: both ends keep identical sets
// RULE25: each copy is one cycle on entry strobe
module lps_manager (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// link state entry strobes and levels
	input wire logic enter_power_off,
	input wire logic enter_cold_start,
	input wire logic enter_warm_start,
	input wire logic enter_error_resume,
	input wire logic enter_steady,
	input wire logic enter_idle,
	input wire logic in_steady,
	input wire logic in_idle,
	// configuration
	input wire logic splitter_present,
	input wire logic [3:0] idle_psd_cut_db,
	// management requests
	input wire lps_pkg::lps_param_set_t mgmt_set,
	input wire logic mgmt_load_warm,
	input wire logic mgmt_load_idle,
	input wire logic change_parameters_signal,
	input wire logic idle_request_signal,
	input wire logic back_to_service_signal,
	// overhead control channel answers
	input wire logic voc_ack,
	input wire logic voc_nak,
	input wire logic trigger_done,
	// overhead control channel messages
	output logic voc_msg_valid,
	output lps_pkg::lps_msg_t voc_msg_code,
	output lps_pkg::lps_param_set_t voc_msg_set,
	// parameter sets in use
	output lps_pkg::lps_param_set_t current_param_set,
	output lps_pkg::lps_param_set_t warm_start_param_set,
	output lps_pkg::lps_param_set_t warm_resume_param_set,
	output lps_pkg::lps_param_set_t error_resume_param_set,
	output lps_pkg::lps_param_set_t idle_param_set,
	// status
	output logic busy,
	output logic change_done,
	output logic change_refused
);

	// ***************************************************
	// default set and idle derivation
	// ***************************************************
	lps_pkg::lps_param_set_t default_param_set;
	lps_pkg::lps_param_set_t idle_auto;
	lps_pkg::lps_regs_t r_q;
	lps_pkg::lps_regs_t r_d;
	lps_pkg::lps_regs_t r_rst;

	always_comb begin
		default_param_set = '0;
		default_param_set.ds_sr_mult = lps_pkg::DEF_DS_SR_MULT; // RULE3
		default_param_set.ds_cf_mult = lps_pkg::DEF_DS_CF_MULT; // RULE3
		default_param_set.ds_const_bits = lps_pkg::DEF_CONST_BITS; // RULE3
		default_param_set.ds_psd_neg_db = lps_pkg::DEF_PSD_NEG_DB;
		default_param_set.us_sr_mult = lps_pkg::DEF_US_SR_MULT;
		default_param_set.us_cf_mult = lps_pkg::DEF_US_CF_MULT;
		default_param_set.us_const_bits = lps_pkg::DEF_CONST_BITS;
		default_param_set.us_psd_neg_db = lps_pkg::DEF_PSD_NEG_DB;
		default_param_set.us2_enable = ~splitter_present; // RULE4
		default_param_set.interleave_enable = 1'b0; // RULE3
		default_param_set.dual_latency = 1'b0; // RULE3
	end

	// largest psd cut allowed for a steady constellation of 2^bits points
	function automatic logic [3:0] cut_limit(input logic [3:0] bits);
		logic [3:0] lim;
		lim = lps_pkg::CUT_MAX_SIZE32;
		if (bits <= 4'h2) begin
			lim = lps_pkg::CUT_MAX_SIZE4;
		end else if (bits == 4'h3) begin
			lim = lps_pkg::CUT_MAX_SIZE8;
		end else if (bits == 4'h4) begin
			lim = lps_pkg::CUT_MAX_SIZE16;
		end
		return lim;
	endfunction

	function automatic logic [7:0] cut_psd(input logic [7:0] neg_db, input logic [3:0] bits,
		input logic [3:0] want);
		logic [3:0] c;
		c = (want > cut_limit(bits)) ? cut_limit(bits) : want; // RULE10
		return neg_db + {4'h0, c};
	endfunction

	always_comb begin
		idle_auto = r_q.cur; // RULE9
		idle_auto.ds_const_bits = lps_pkg::IDLE_CONST_BITS; // RULE9
		idle_auto.us_const_bits = lps_pkg::IDLE_CONST_BITS; // RULE9
		idle_auto.ds_psd_neg_db = cut_psd(r_q.cur.ds_psd_neg_db, r_q.cur.ds_const_bits, idle_psd_cut_db);
		idle_auto.us_psd_neg_db = cut_psd(r_q.cur.us_psd_neg_db, r_q.cur.us_const_bits, idle_psd_cut_db);
	end

	// ***************************************************
	// next state
	// ***************************************************
	always_comb begin
		r_rst = '0;
		r_rst.state = lps_pkg::ST_READY;
		r_rst.op = lps_pkg::MSG_NONE;
		r_rst.msg_code = lps_pkg::MSG_NONE;
	end

	always_comb begin
		r_d = r_q;
		r_d.msg_valid = 1'b0;
		r_d.done = 1'b0;
		r_d.refused = 1'b0;
		// idle set follows current unless a custom one was agreed
		if (!r_q.idle_custom) begin
			r_d.idle = idle_auto; // RULE9
		end
		// error-resume tracks current while steady or idle
		if (in_steady || in_idle) begin
			r_d.eres = r_q.cur; // RULE8
		end
		case (r_q.state)
			lps_pkg::ST_READY: begin
				if (in_steady && mgmt_load_warm) begin // RULE14
					r_d.op = lps_pkg::MSG_SET_WARM;
				end else if (in_steady && mgmt_load_idle) begin // RULE14 RULE11
					r_d.op = lps_pkg::MSG_SET_IDLE;
				end else if (in_steady && change_parameters_signal) begin // RULE18
					r_d.op = lps_pkg::MSG_SET_CUR;
				end else if (in_steady && idle_request_signal) begin // RULE18
					r_d.op = lps_pkg::MSG_IDLE_REQ;
				end else if (in_idle && back_to_service_signal) begin // RULE18
					r_d.op = lps_pkg::MSG_BACK_SERV;
				end else begin
					r_d.op = lps_pkg::MSG_NONE;
					r_d.refused = mgmt_load_warm | mgmt_load_idle | change_parameters_signal |
						idle_request_signal | back_to_service_signal;
				end
				if (r_d.op != lps_pkg::MSG_NONE) begin
					r_d.staged = mgmt_set;
					r_d.msg_valid = 1'b1; // RULE15 RULE12
					r_d.msg_code = r_d.op;
					r_d.msg_set = (r_d.op == lps_pkg::MSG_IDLE_REQ) ? r_q.idle :
						(r_d.op == lps_pkg::MSG_BACK_SERV) ? r_q.wres : mgmt_set;
					r_d.busy = 1'b1;
					r_d.state = lps_pkg::ST_WAIT_ACK;
				end
			end
			lps_pkg::ST_WAIT_ACK: begin
				if (voc_nak) begin // RULE13
					r_d.refused = 1'b1;
					r_d.busy = 1'b0;
					r_d.state = lps_pkg::ST_READY;
				end else if (voc_ack) begin
					case (r_q.op)
						lps_pkg::MSG_SET_WARM: begin
							r_d.warm = r_q.staged; // RULE6 RULE15 RULE22
							r_d.done = 1'b1;
							r_d.busy = 1'b0;
							r_d.state = lps_pkg::ST_READY;
						end
						lps_pkg::MSG_SET_IDLE: begin
							r_d.idle = r_q.staged; // RULE11 RULE15
							r_d.idle_custom = 1'b1;
							r_d.done = 1'b1;
							r_d.busy = 1'b0;
							r_d.state = lps_pkg::ST_READY;
						end
						lps_pkg::MSG_SET_CUR: begin
							// new set delivered, now the change message
							r_d.op = lps_pkg::MSG_CHANGE; // RULE19
							r_d.msg_valid = 1'b1;
							r_d.msg_code = lps_pkg::MSG_CHANGE;
						end
						default: begin
							r_d.state = lps_pkg::ST_WAIT_TRIG; // RULE17
						end
					endcase
				end
			end
			lps_pkg::ST_WAIT_TRIG: begin
				if (trigger_done) begin // RULE17
					case (r_q.op)
						lps_pkg::MSG_CHANGE: begin
							r_d.cur = r_q.staged; // RULE19 RULE23
							r_d.eres = r_q.staged; // RULE19 RULE21
						end
						lps_pkg::MSG_IDLE_REQ: begin
							r_d.cur = r_q.idle; // RULE20
							r_d.eres = r_q.idle; // RULE20
						end
						default: begin
							r_d.cur = r_q.wres; // RULE20
							r_d.eres = r_q.wres; // RULE20
						end
					endcase
					r_d.done = 1'b1;
					r_d.busy = 1'b0;
					r_d.state = lps_pkg::ST_READY;
				end
			end
			default: begin
				r_d.state = lps_pkg::ST_READY;
			end
		endcase
		// link state entries win over any pending exchange
		if (enter_steady) begin
			r_d.wres = r_q.cur; // RULE7 RULE25
			r_d.eres = r_q.cur; // RULE8 RULE25
		end
		if (enter_idle) begin
			r_d.eres = r_q.cur; // RULE8 RULE25
		end
		if (enter_power_off || enter_cold_start || enter_warm_start || enter_error_resume) begin
			r_d.state = lps_pkg::ST_READY;
			r_d.busy = 1'b0;
			r_d.msg_valid = 1'b0;
			r_d.refused = r_q.busy;
			r_d.done = 1'b0;
		end
		if (enter_power_off) begin
			r_d.warm = default_param_set; // RULE5 RULE2
			r_d.idle_custom = 1'b0;
		end
		if (enter_cold_start) begin
			r_d.cur = default_param_set; // RULE16 RULE2 RULE22 RULE25
		end else if (enter_warm_start) begin
			r_d.cur = r_q.warm; // RULE16 RULE21 RULE25
		end else if (enter_error_resume) begin
			r_d.cur = r_q.eres; // RULE16 RULE21 RULE25
		end
	end

	// ***************************************************
	// state register
	// ***************************************************
	// reset loads warm-start with the constant default fields; current resets to zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= r_rst;
			r_q.warm.ds_sr_mult <= lps_pkg::DEF_DS_SR_MULT; // RULE5
			r_q.warm.ds_cf_mult <= lps_pkg::DEF_DS_CF_MULT;
			r_q.warm.ds_const_bits <= lps_pkg::DEF_CONST_BITS;
			r_q.warm.ds_psd_neg_db <= lps_pkg::DEF_PSD_NEG_DB;
			r_q.warm.us_sr_mult <= lps_pkg::DEF_US_SR_MULT;
			r_q.warm.us_cf_mult <= lps_pkg::DEF_US_CF_MULT;
			r_q.warm.us_const_bits <= lps_pkg::DEF_CONST_BITS;
			r_q.warm.us_psd_neg_db <= lps_pkg::DEF_PSD_NEG_DB;
		end else begin
			r_q <= r_d;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign voc_msg_valid = r_q.msg_valid;
	assign voc_msg_code = r_q.msg_code;
	assign voc_msg_set = r_q.msg_set;
	assign current_param_set = r_q.cur; // RULE1 RULE24
	assign warm_start_param_set = r_q.warm; // RULE1
	assign warm_resume_param_set = r_q.wres; // RULE1
	assign error_resume_param_set = r_q.eres; // RULE1
	assign idle_param_set = r_q.idle; // RULE1
	assign busy = r_q.busy;
	assign change_done = r_q.done;
	assign change_refused = r_q.refused;

endmodule

`default_nettype wire

// >>> pkg/lps_pkg.sv
// lps_pkg: types and constants of the line parameter set manager.
// assumes one core clock domain; rate and frequency fields are in units of their grid step.
package lps_pkg;

	// one transmission parameter set, rate and frequency fields in grid steps
	typedef struct packed {
		logic [7:0] ds_sr_mult;
		logic [9:0] ds_cf_mult;
		logic [3:0] ds_const_bits;
		logic [7:0] ds_psd_neg_db;
		logic [7:0] us_sr_mult;
		logic [9:0] us_cf_mult;
		logic [3:0] us_const_bits;
		logic [7:0] us_psd_neg_db;
		logic us2_enable;
		logic interleave_enable;
		logic dual_latency;
	} lps_param_set_t;

	// ***************************************************
	// default parameter set values
	// ***************************************************
	// 573.75 kbaud = 17 x 33.75, 1451.25 kHz = 86 x 16.875
	localparam logic [7:0] DEF_DS_SR_MULT = 8'h11;
	localparam logic [9:0] DEF_DS_CF_MULT = 10'h056;
	// 742.5 kbaud = 22 x 33.75, 4455 kHz = 264 x 16.875
	localparam logic [7:0] DEF_US_SR_MULT = 8'h16;
	localparam logic [9:0] DEF_US_CF_MULT = 10'h108;
	localparam logic [3:0] DEF_CONST_BITS = 4'h4;
	localparam logic [7:0] DEF_PSD_NEG_DB = 8'h3C;

	// idle set constellation and per-size limits on psd cut
	localparam logic [3:0] IDLE_CONST_BITS = 4'h4;
	localparam logic [3:0] CUT_MAX_SIZE4 = 4'h3;
	localparam logic [3:0] CUT_MAX_SIZE8 = 4'h7;
	localparam logic [3:0] CUT_MAX_SIZE16 = 4'hA;
	localparam logic [3:0] CUT_MAX_SIZE32 = 4'hC;

	// overhead channel message codes
	typedef enum logic [2:0] {
		MSG_NONE = 3'h0,
		MSG_SET_WARM = 3'h1,
		MSG_SET_IDLE = 3'h2,
		MSG_SET_CUR = 3'h3,
		MSG_CHANGE = 3'h4,
		MSG_IDLE_REQ = 3'h5,
		MSG_BACK_SERV = 3'h6
	} lps_msg_t;

	typedef enum logic [1:0] {
		ST_READY = 2'h0,
		ST_WAIT_ACK = 2'h1,
		ST_WAIT_TRIG = 2'h3
	} lps_state_t;

	typedef struct packed {
		lps_state_t state;
		lps_msg_t op;
		lps_param_set_t cur;
		lps_param_set_t warm;
		lps_param_set_t wres;
		lps_param_set_t eres;
		lps_param_set_t idle;
		lps_param_set_t staged;
		logic idle_custom;
		logic msg_valid;
		lps_msg_t msg_code;
		lps_param_set_t msg_set;
		logic busy;
		logic done;
		logic refused;
	} lps_regs_t;

endpackage

// >>> verif/lps_manager_chk.sv
// lps_manager_chk: port-level checks of lps_manager.
// assumes one clock domain; bound into every lps_manager.
`timescale 1ns/1ps
`default_nettype none
module lps_manager_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// link state
	input wire logic enter_cold_start,
	input wire logic enter_warm_start,
	input wire logic enter_error_resume,
	input wire logic enter_steady,
	input wire logic in_steady,
	// requests and answers
	input wire logic change_parameters_signal,
	input wire logic voc_nak,
	// manager outputs
	input wire logic voc_msg_valid,
	input wire lps_pkg::lps_param_set_t current_param_set,
	input wire lps_pkg::lps_param_set_t warm_start_param_set,
	input wire lps_pkg::lps_param_set_t warm_resume_param_set,
	input wire lps_pkg::lps_param_set_t error_resume_param_set,
	input wire logic busy,
	input wire logic change_refused
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	cold_load_a: assert property (enter_cold_start |=> current_param_set.ds_sr_mult == 8'h11 && current_param_set.ds_cf_mult == 10'h056)
		else $error("cold start load wrong");
	warm_load_a: assert property (enter_warm_start |=> current_param_set == $past(warm_start_param_set))
		else $error("warm start load wrong");
	eres_load_a: assert property (enter_error_resume |=> current_param_set == $past(error_resume_param_set))
		else $error("error resume load wrong");
	steady_copy_a: assert property (enter_steady |=> warm_resume_param_set == $past(current_param_set))
		else $error("warm resume copy wrong");
	eres_track_a: assert property (in_steady && $past(in_steady) && $stable(current_param_set)
		|-> error_resume_param_set == current_param_set) else $error("error resume not tracking");
	chg_state_a: assert property (change_parameters_signal && !in_steady && !busy |=> change_refused)
		else $error("change outside steady not refused");
	nak_refuse_a: assert property (voc_nak && busy |=> change_refused && !busy)
		else $error("nak not refused");
	msg_busy_a: assert property (voc_msg_valid |-> busy)
		else $error("message without busy");
endmodule
bind lps_manager lps_manager_chk u_chk (.sys_clk, .rst_n, .enter_cold_start, .enter_warm_start,
	.enter_error_resume, .enter_steady, .in_steady, .change_parameters_signal, .voc_nak, .voc_msg_valid,
	.current_param_set, .warm_start_param_set, .warm_resume_param_set, .error_resume_param_set, .busy,
	.change_refused);
`default_nettype wire

// >>> verif/lps_remote_model.sv
// lps_remote_model: customer-side end answering overhead messages.
// assumes message code and set hold after the valid pulse.
`timescale 1ns/1ps
`default_nettype none
module lps_remote_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// scenario controls
	input wire logic refuse,
	input wire logic [3:0] lag,
	// messages in
	input wire logic msg_valid,
	input wire lps_pkg::lps_msg_t msg_code,
	input wire lps_pkg::lps_param_set_t msg_set,
	// answers and remote copy
	output logic ack,
	output logic nak,
	output logic trig_done,
	output lps_pkg::lps_param_set_t rmt_set
);
	logic pend_q;
	logic trig_q;
	logic [3:0] cnt_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{pend_q, trig_q, cnt_q, ack, nak, trig_done} <= '0;
			rmt_set <= '0;
		end else begin
			ack <= 1'b0;
			nak <= 1'b0;
			trig_done <= trig_q;
			trig_q <= 1'b0;
			if (msg_valid && lag != 4'h0) begin
				pend_q <= 1'b1;
				cnt_q <= lag - 4'h1;
			end else if (pend_q && cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end else if (pend_q || msg_valid) begin
				pend_q <= 1'b0;
				ack <= !refuse;
				nak <= refuse;
				trig_q <= !refuse && msg_code inside {lps_pkg::MSG_CHANGE, lps_pkg::MSG_IDLE_REQ,
					lps_pkg::MSG_BACK_SERV};
				if (!refuse && msg_code != lps_pkg::MSG_CHANGE) begin
					rmt_set <= msg_set;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/test_line_parameter_set_manager.sv
// test_line_parameter_set_manager: directed bench of lps_manager.
// assumes the remote model answers every message.
`timescale 1ns/1ps
`default_nettype none
module test_line_parameter_set_manager;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] ent = '0;
	logic [4:0] req = '0;
	logic in_st = 1'b0;
	logic in_id = 1'b0;
	logic refuse = 1'b0;
	logic [3:0] lag = 4'h0;
	logic ack, nak, trig, mvalid, busy, done, refused;
	lps_pkg::lps_msg_t mcode;
	lps_pkg::lps_param_set_t mset, rmt, cur, warm, wres, eres, idle, def, s1, s2;
	lps_pkg::lps_param_set_t req_set = '0;
	logic [1:0] r;
	int n_errors = 0;
	int checks_done = 0;
	always #2.5 sys_clk = ~sys_clk;
	lps_manager DUT (.sys_clk, .rst_n, .enter_power_off(ent[0]), .enter_cold_start(ent[1]),
		.enter_warm_start(ent[2]), .enter_error_resume(ent[3]), .enter_steady(ent[4]), .enter_idle(ent[5]),
		.in_steady(in_st), .in_idle(in_id), .splitter_present(1'b1), .idle_psd_cut_db(4'hF),
		.mgmt_set(req_set), .mgmt_load_warm(req[0]), .mgmt_load_idle(req[1]), .change_parameters_signal(req[2]),
		.idle_request_signal(req[3]), .back_to_service_signal(req[4]), .voc_ack(ack), .voc_nak(nak),
		.trigger_done(trig), .voc_msg_valid(mvalid), .voc_msg_code(mcode), .voc_msg_set(mset),
		.current_param_set(cur), .warm_start_param_set(warm), .warm_resume_param_set(wres),
		.error_resume_param_set(eres), .idle_param_set(idle), .busy, .change_done(done), .change_refused(refused));
	lps_remote_model u_rmt (.sys_clk, .rst_n, .refuse, .lag, .msg_valid(mvalid), .msg_code(mcode),
		.msg_set(mset), .ack, .nak, .trig_done(trig), .rmt_set(rmt));
	task automatic check(input string nm, input logic [65:0] seen, input logic [65:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic ent_go(input int i);
		ent[i] = 1'b1;
		@(negedge sys_clk);
		ent[i] = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic req_go(input int i, input lps_pkg::lps_param_set_t s);
		int k;
		req_set = s;
		req[i] = 1'b1;
		@(negedge sys_clk);
		req[i] = 1'b0;
		for (k = 0; k < 60 && (done | refused) !== 1'b1; k++) begin
			@(negedge sys_clk);
		end
		if (k == 60) begin
			n_errors++;
			report_and_stop();
		end
		r = {done, refused};
		@(negedge sys_clk);
	endtask
	initial begin
		def = '{8'h11, 10'h056, 4'h4, 8'h3C, 8'h16, 10'h108, 4'h4, 8'h3C, 1'b0, 1'b0, 1'b0};
		s1 = def;
		s1.us_sr_mult = 8'h1C;
		s2 = def;
		s2.ds_sr_mult = 8'h22;
		s2.ds_const_bits = 4'h5;
		repeat (16) @(negedge sys_clk);
		rst_n = 1'b1;
		check("warm", warm, def);
		check("cur", cur, '0);
		ent_go(1);
		check("cold", cur, def);
		in_st = 1'b1;
		ent_go(4);
		check("wres", wres, def);
		check("idle", {idle.ds_const_bits, idle.ds_psd_neg_db}, {4'h4, 8'h46});
		req_go(0, s1);
		check("warm_set", {r, warm}, {2'b10, s1});
		lag = 4'h3;
		refuse = 1'b1;
		req_go(2, s2);
		check("nak", {r, cur}, {2'b01, def});
		check("nak_busy", busy, 1'b0);
		refuse = 1'b0;
		req_go(2, s2);
		check("chg", {r, cur}, {2'b10, s2});
		check("eres", eres, s2);
		check("chg_code", mcode, lps_pkg::MSG_CHANGE);
		check("chg_busy", {busy, mvalid}, 2'b00);
		check("remote", rmt, s2);
		lag = 4'h0;
		req_go(3, def);
		check("idle_req", {r, cur.ds_sr_mult, cur.ds_const_bits, cur.ds_psd_neg_db},
			{2'b10, 8'h22, 4'h4, 8'h48});
		in_st = 1'b0;
		in_id = 1'b1;
		ent_go(5);
		req_go(2, s1);
		check("chg_idle", r, 2'b01);
		req_go(4, def);
		check("back", {r, cur}, {2'b10, def});
		in_id = 1'b0;
		ent_go(2);
		check("warm_ent", cur, s1);
		ent_go(3);
		check("eres_ent", cur, def);
		ent_go(0);
		check("pwr_off", warm, def);
		report_and_stop();
	end
endmodule
`default_nettype wire
